// *** htu_pkg.sv ***
package htu_pkg;

    // ************************************************************
    // Clock and baud constants
    // ************************************************************
    localparam int CLK_HZ = 125000000;
    localparam int BAUD_MIN = 115200;
    localparam int BAUD_MAX = 3000000;
    localparam int BAUD_RESET = 115200;
    localparam int RATE_W = 22;
    localparam int ACC_W = 28;
    localparam int OVERSAMPLE_LOG2 = 4;

    // ************************************************************
    // Character framing
    // ************************************************************
    localparam int DATA_BITS = 8;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_MID = 4'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ************************************************************
    // Buffer sizing and flow control
    // ************************************************************
    localparam int HOST_FIFO_DEPTH = 1040;
    localparam int PERIPH_FIFO_DEPTH = 256;
    localparam int RTS_MARGIN = 16;

    // One-hot bit engine states shared by both directions
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } htu_bit_state_t;

endpackage : htu_pkg

// *** htu_fifo.sv ***
`timescale 1ns/1ps
module htu_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [CW-1:0] count_q;
    logic [CW-1:0] count_d;
    logic in_ready_q;
    logic out_valid_q;
    logic push;
    logic pop;

    assign push = in_valid && in_ready_q;
    assign pop = out_valid_q && out_ready;

    // Depth need not be a power of two, so pointers wrap explicitly
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    // Storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr_q] <= in_data;
    end

    // Occupancy and registered handshake flags
    always_comb
    begin
        count_d = count_q;
        if (push && !pop)
            count_d = count_q + 1'b1;
        else if (pop && !push)
            count_d = count_q - 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= '0;
            in_ready_q <= 1'b1;
            out_valid_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            in_ready_q <= (count_d != CNT_FULL);
            out_valid_q <= (count_d != '0);
        end
    end

    assign in_ready = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data = mem[rd_ptr_q];
    assign level = count_q;

    // Never holds more than its depth
    property p_fifo_bound;
        @(posedge clk) disable iff (rst)
        push && !pop |=> count_q == $past(count_q) + 1'b1
                         && count_q <= CNT_FULL;
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo occupancy wrong after push");

endmodule : htu_fifo

// *** htu_uart_top.sv ***
`timescale 1ns/1ps
module htu_uart_top
import htu_pkg::*;
#(
    parameter int FIFO_DEPTH = HOST_FIFO_DEPTH
)
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic rx_in,
    output logic tx_out,
    output logic rts_n,
    input wire logic cts_n,
    input wire logic device_wake_request,
    output logic host_wake,
    input wire logic [7:0] user_tx_data,
    input wire logic user_tx_valid,
    output logic user_tx_ready,
    output logic [7:0] user_rx_data,
    output logic user_rx_valid,
    input wire logic user_rx_ready,
    input wire logic [RATE_W-1:0] baud_rate,
    input wire logic baud_load,
    input wire logic wake_enable,
    input wire logic host_wake_req,
    output logic device_sleep_ok,
    output logic rx_frame_error,
    output logic rx_overrun
);
    localparam int CW = $clog2(FIFO_DEPTH+1);
    localparam logic [CW-1:0] RTS_LEVEL = CW'(FIFO_DEPTH - RTS_MARGIN);
    localparam logic [ACC_W:0] CLK_WRAP = (ACC_W+1)'(CLK_HZ);

    // ************************************************************
    // Baud rate selection
    // ************************************************************
    logic [RATE_W-1:0] rate_q;
    logic loaded_q;
    logic [ACC_W-1:0] acc_q;
    logic tick_q;
    logic [ACC_W:0] acc_sum;
    logic rate_ok;

    // Out-of-range requests are ignored, keeping the old rate
    assign rate_ok = baud_rate >= RATE_W'(BAUD_MIN)
                  && baud_rate <= RATE_W'(BAUD_MAX);

    // Rate is live-switchable; the next tick already uses it
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rate_q <= RATE_W'(BAUD_RESET);
            loaded_q <= 1'b0;
        end
        else if (baud_load && rate_ok)
        begin
            rate_q <= baud_rate;
            loaded_q <= 1'b1;
        end
    end

    // Fractional accumulator gives any rate in range, not only divisors
    assign acc_sum = (ACC_W+1)'(acc_q)
                   + (ACC_W+1)'({rate_q, OVERSAMPLE_LOG2'(0)});

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_q <= '0;
            tick_q <= 1'b0;
        end
        else if (acc_sum >= CLK_WRAP)
        begin
            acc_q <= ACC_W'(acc_sum - CLK_WRAP);
            tick_q <= 1'b1;
        end
        else
        begin
            acc_q <= ACC_W'(acc_sum);
            tick_q <= 1'b0;
        end
    end

    // ************************************************************
    // Buffers
    // ************************************************************
    logic [7:0] txf_data;
    logic txf_valid;
    logic txf_pop;
    logic [7:0] rx_byte_q;
    logic rx_push_q;
    logic rxf_ready;
    logic [CW-1:0] rx_level;

    // Bytes pass untouched; H4 type bytes are framed by the host stack
    htu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo
    (
        .clk(ref_clk),
        .rst(rst),
        .in_data(user_tx_data),
        .in_valid(user_tx_valid),
        .in_ready(user_tx_ready),
        .out_data(txf_data),
        .out_valid(txf_valid),
        .out_ready(txf_pop),
        .level()
    );

    htu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo
    (
        .clk(ref_clk),
        .rst(rst),
        .in_data(rx_byte_q),
        .in_valid(rx_push_q),
        .in_ready(rxf_ready),
        .out_data(user_rx_data),
        .out_valid(user_rx_valid),
        .out_ready(user_rx_ready),
        .level(rx_level)
    );

    // ************************************************************
    // Transmitter
    // ************************************************************
    htu_bit_state_t tx_state_q;
    logic [3:0] tx_tick_q;
    logic [2:0] tx_bit_q;
    logic [7:0] tx_shift_q;
    logic tx_out_q;

    // A byte only starts while the host grants; a running byte finishes
    assign txf_pop = (tx_state_q == ST_IDLE) && txf_valid && !cts_n;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_state_q <= ST_IDLE;
            tx_tick_q <= '0;
            tx_bit_q <= '0;
            tx_shift_q <= '0;
            tx_out_q <= 1'b1;
        end
        else
        begin
            unique case (tx_state_q)
                ST_IDLE:
                begin
                    tx_out_q <= 1'b1;
                    tx_tick_q <= '0;
                    if (txf_pop)
                    begin
                        tx_shift_q <= txf_data;
                        tx_out_q <= 1'b0;
                        tx_state_q <= ST_START;
                    end
                end
                ST_START:
                begin
                    if (tick_q)
                    begin
                        tx_tick_q <= tx_tick_q + 1'b1;
                        if (tx_tick_q == TICK_LAST)
                        begin
                            tx_out_q <= tx_shift_q[0];
                            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            tx_bit_q <= '0;
                            tx_state_q <= ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (tick_q)
                    begin
                        tx_tick_q <= tx_tick_q + 1'b1;
                        if (tx_tick_q == TICK_LAST)
                        begin
                            tx_bit_q <= tx_bit_q + 1'b1;
                            if (tx_bit_q == BIT_LAST)
                            begin
                                tx_out_q <= 1'b1;
                                tx_state_q <= ST_STOP;
                            end
                            else
                            begin
                                tx_out_q <= tx_shift_q[0];
                                tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                            end
                        end
                    end
                end
                ST_STOP:
                begin
                    if (tick_q)
                    begin
                        tx_tick_q <= tx_tick_q + 1'b1;
                        if (tx_tick_q == TICK_LAST)
                            tx_state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    htu_bit_state_t rx_state_q;
    logic [3:0] rx_tick_q;
    logic [2:0] rx_bit_q;
    logic [7:0] rx_shift_q;
    logic rx_q;
    logic rx_err_q;
    logic rx_ovr_q;

    // Registered copy of the line for the sampling logic
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rx_q <= 1'b1;
        else
            rx_q <= rx_in;
    end

    // Samples mid-bit, so about half a bit of drift over a frame is fine
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rx_state_q <= ST_IDLE;
            rx_tick_q <= '0;
            rx_bit_q <= '0;
            rx_shift_q <= '0;
            rx_byte_q <= '0;
            rx_push_q <= 1'b0;
            rx_err_q <= 1'b0;
            rx_ovr_q <= 1'b0;
        end
        else
        begin
            rx_push_q <= 1'b0;
            rx_err_q <= 1'b0;
            rx_ovr_q <= 1'b0;
            unique case (rx_state_q)
                ST_IDLE:
                begin
                    rx_tick_q <= '0;
                    if (tick_q && !rx_q)
                        rx_state_q <= ST_START;
                end
                ST_START:
                begin
                    if (tick_q)
                    begin
                        rx_tick_q <= rx_tick_q + 1'b1;
                        if (rx_tick_q == TICK_MID)
                        begin
                            // A short low glitch is not a start bit
                            rx_tick_q <= '0;
                            rx_bit_q <= '0;
                            rx_state_q <= rx_q ? ST_IDLE : ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (tick_q)
                    begin
                        rx_tick_q <= rx_tick_q + 1'b1;
                        if (rx_tick_q == TICK_LAST)
                        begin
                            rx_shift_q <= {rx_q, rx_shift_q[7:1]};
                            rx_bit_q <= rx_bit_q + 1'b1;
                            if (rx_bit_q == BIT_LAST)
                                rx_state_q <= ST_STOP;
                        end
                    end
                end
                ST_STOP:
                begin
                    if (tick_q)
                    begin
                        rx_tick_q <= rx_tick_q + 1'b1;
                        if (rx_tick_q == TICK_LAST)
                        begin
                            rx_state_q <= ST_IDLE;
                            if (!rx_q)
                                rx_err_q <= 1'b1;
                            else if (!rxf_ready)
                                rx_ovr_q <= 1'b1;
                            else
                            begin
                                rx_byte_q <= rx_shift_q;
                                rx_push_q <= 1'b1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Flow control and wake lines
    // ************************************************************
    logic rts_n_q;
    logic wake_en_q;
    logic host_wake_q;
    logic sleep_ok_q;

    // Margin leaves room for bytes the host sends before it sees the drop
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rts_n_q <= 1'b1;
        else
            rts_n_q <= (rx_level >= RTS_LEVEL);
    end

    // Both sidebands held inactive until enabled by command
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wake_en_q <= 1'b0;
            host_wake_q <= 1'b0;
            sleep_ok_q <= 1'b0;
        end
        else
        begin
            wake_en_q <= wake_enable;
            host_wake_q <= wake_en_q && host_wake_req;
            sleep_ok_q <= wake_en_q && !device_wake_request;
        end
    end

    // Every line is a port of its own, so pin muxing outside can route it
    assign tx_out = tx_out_q;
    assign rts_n = rts_n_q;
    assign host_wake = host_wake_q;
    assign device_sleep_ok = sleep_ok_q;
    assign rx_frame_error = rx_err_q;
    assign rx_overrun = rx_ovr_q;

    // ************************************************************
    // Checks
    // ************************************************************
    sequence s_leave_idle;
        tx_state_q == ST_IDLE ##1 tx_state_q == ST_START;
    endsequence

    sequence s_start_low;
        !tx_out_q [*2];
    endsequence

    property p_rate_range;
        @(posedge ref_clk) disable iff (rst)
        rate_q >= RATE_W'(BAUD_MIN) && rate_q <= RATE_W'(BAUD_MAX);
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("baud rate outside range");

    property p_reset_rate;
        @(posedge ref_clk) disable iff (rst)
        !loaded_q |-> rate_q == RATE_W'(BAUD_RESET);
    endproperty
    a_reset_rate: assert property (p_reset_rate)
        else $error("rate not default before any load");

    property p_load_applies;
        @(posedge ref_clk) disable iff (rst)
        baud_load && rate_ok |=> rate_q == $past(baud_rate);
    endproperty
    a_load_applies: assert property (p_load_applies)
        else $error("new baud rate not taken");

    property p_cts_hold;
        @(posedge ref_clk) disable iff (rst)
        tx_state_q == ST_IDLE && cts_n |=> tx_state_q == ST_IDLE;
    endproperty
    a_cts_hold: assert property (p_cts_hold)
        else $error("transmit started without clear-to-send");

    property p_rts_drop;
        @(posedge ref_clk) disable iff (rst)
        rx_level >= RTS_LEVEL |=> rts_n_q;
    endproperty
    a_rts_drop: assert property (p_rts_drop)
        else $error("request-to-send kept near full");

    property p_wake_off;
        @(posedge ref_clk) disable iff (rst)
        !wake_en_q |=> !host_wake_q && !sleep_ok_q;
    endproperty
    a_wake_off: assert property (p_wake_off)
        else $error("wake line active while disabled");

    property p_start_bit;
        @(posedge ref_clk) disable iff (rst)
        s_leave_idle |-> s_start_low;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit not low");

    property p_stop_bit;
        @(posedge ref_clk) disable iff (rst)
        tx_state_q == ST_STOP |-> tx_out_q;
    endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("stop bit not high");

endmodule : htu_uart_top

// *** htu_host_model.sv ***
`timescale 1ns/1ps
// ************************************************************
// Host side of the serial link
// ************************************************************
module htu_host_model
(
    input wire logic tx_line,
    input wire logic rts_n,
    output logic rx_line
);
    real bit_ns = 8680.5;
    bit ignore_rts = 1'b0;
    logic [7:0] got_q[$];
    int bad_stop = 0;

    // Line idles high between characters
    initial rx_line = 1'b1;

    // One character; scale skews the bit time, stop may be broken
    task automatic send_byte(input logic [7:0] b, input logic stop,
                             input real scale);
        real t;
        t = bit_ns * scale;
        // Hold off while the device asks for a pause
        while (rts_n === 1'b1 && !ignore_rts) #(t);
        rx_line = 1'b0;
        #(t);
        for (int i = 0; i < 8; i++)
        begin
            rx_line = b[i];
            #(t);
        end
        rx_line = stop;
        #(t);
        rx_line = 1'b1;
    endtask : send_byte

    // Sample device characters at bit centres, LSB first
    initial
    begin
        logic [7:0] v;
        forever
        begin
            @(negedge tx_line);
            #(bit_ns / 2);
            for (int i = 0; i < 8; i++)
            begin
                #(bit_ns);
                v[i] = tx_line;
            end
            #(bit_ns);
            if (tx_line !== 1'b1)
                bad_stop++;
            got_q.push_back(v);
        end
    end
endmodule : htu_host_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench import htu_pkg::*;;
    // Small depth so full and pause thresholds are reachable
    localparam int DEPTH = 32;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic rx_in, tx_out, rts_n, host_wake, device_sleep_ok;
    logic cts_n = 1'b0;
    logic device_wake_request = 1'b0;
    logic wake_enable = 1'b0;
    logic host_wake_req = 1'b0;
    logic [7:0] user_tx_data = 8'h00;
    logic user_tx_valid = 1'b0;
    logic user_rx_ready = 1'b0;
    logic [RATE_W-1:0] baud_rate = 22'h1C200;
    logic baud_load = 1'b0;
    logic user_tx_ready, user_rx_valid, rx_frame_error, rx_overrun;
    logic [7:0] user_rx_data;
    int bad_count = 0;
    int tests_run = 0;
    int ovr_cnt = 0;
    int ferr_cnt = 0;
    logic [RATE_W-1:0] rates[4] = '{22'hE1000, 22'h16E360, 22'h1E8480,
                                   22'h2DC6C0};

    always #4 ref_clk = ~ref_clk;

    htu_uart_top #(.FIFO_DEPTH(DEPTH)) htu_uart_top_i (.ref_clk(ref_clk),
        .rst(rst), .rx_in(rx_in), .tx_out(tx_out), .rts_n(rts_n),
        .cts_n(cts_n), .device_wake_request(device_wake_request),
        .host_wake(host_wake), .user_tx_data(user_tx_data),
        .user_tx_valid(user_tx_valid), .user_tx_ready(user_tx_ready),
        .user_rx_data(user_rx_data), .user_rx_valid(user_rx_valid),
        .user_rx_ready(user_rx_ready), .baud_rate(baud_rate),
        .baud_load(baud_load), .wake_enable(wake_enable),
        .host_wake_req(host_wake_req), .device_sleep_ok(device_sleep_ok),
        .rx_frame_error(rx_frame_error), .rx_overrun(rx_overrun));

    htu_host_model htu_host_model_i (.tx_line(tx_out), .rts_n(rts_n),
        .rx_line(rx_in));

    // Count one-cycle error pulses as they pass, sampled where settled
    always @(negedge ref_clk)
    begin
        if (rx_overrun === 1'b1)
            ovr_cnt++;
        if (rx_frame_error === 1'b1)
            ferr_cnt++;
    end

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Load takes one pulse; the host follows only accepted rates
    task automatic set_rate(input logic [RATE_W-1:0] r, input bit take);
        @(negedge ref_clk);
        baud_rate = r;
        baud_load = 1'b1;
        @(negedge ref_clk);
        baud_load = 1'b0;
        if (take)
            htu_host_model_i.bit_ns = 1.0e9 / r;
    endtask : set_rate

    // Ready is a register, so its value at the falling edge is taken
    task automatic push_tx(input logic [7:0] b);
        int n = 0;
        @(negedge ref_clk);
        user_tx_data = b;
        user_tx_valid = 1'b1;
        while (user_tx_ready !== 1'b1 && n < 50000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("user_tx_ready", user_tx_ready, 1'h1);
        @(negedge ref_clk);
        user_tx_valid = 1'b0;
    endtask : push_tx

    task automatic pop_rx(input logic [7:0] exp);
        int n = 0;
        @(negedge ref_clk);
        while (user_rx_valid !== 1'b1 && n < 40000)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("user_rx_valid", user_rx_valid, 1'h1);
        chk("user_rx_data", user_rx_data, exp);
        user_rx_ready = 1'b1;
        @(negedge ref_clk);
        user_rx_ready = 1'b0;
    endtask : pop_rx

    task automatic host_rx(input logic [7:0] exp);
        int n = 0;
        logic [7:0] v;
        while (htu_host_model_i.got_q.size() == 0 && n < 40000)
        begin
            @(negedge ref_clk);
            n++;
        end
        v = n < 40000 ? htu_host_model_i.got_q.pop_front() : 8'hXX;
        chk("host byte", v, exp);
    endtask : host_rx

    // Both directions, host sends skewed either way by four percent, host receives at the exact rate
    task automatic t_link(input string name);
        htu_host_model_i.send_byte(8'h01, 1'h1, 1.04);
        pop_rx(8'h01);
        htu_host_model_i.send_byte(8'hA5, 1'h1, 0.96);
        pop_rx(8'hA5);
        push_tx(8'h04);
        push_tx(8'h5A);
        host_rx(8'h04);
        host_rx(8'h5A);
        $display("test %s done", name);
    endtask : t_link

    // Pause by clear-to-send, fill until refused, then drain in order
    task automatic t_tx_fill();
        int n = 0;
        cts_n = 1'b1;
        while (user_tx_ready === 1'b1 && n < 40)
        begin
            push_tx(8'h40 + n[7:0]);
            n++;
        end
        chk("tx fill count", n, DEPTH);
        repeat (1000) @(negedge ref_clk);
        chk("tx silent", htu_host_model_i.got_q.size(), 0);
        cts_n = 1'b0;
        for (int i = 0; i < DEPTH; i++)
            host_rx(8'h40 + i[7:0]);
        $display("test tx_fill done");
    endtask : t_tx_fill

    // Receiver stalled: pause request at half full (16 of 32), then one overrun
    task automatic t_rx_fill();
        htu_host_model_i.ignore_rts = 1'b1;
        for (int i = 0; i <= DEPTH; i++)
        begin
            htu_host_model_i.send_byte(8'h80 + i[7:0], 1'h1, 1.0);
            repeat (4) @(negedge ref_clk);
            if (i == DEPTH - 18)
                chk("rts_n below mark", rts_n, 1'h0);
            if (i == DEPTH - 17)
                chk("rts_n at mark", rts_n, 1'h1);
        end
        chk("overrun pulses", ovr_cnt, 1);
        for (int i = 0; i < DEPTH; i++)
            pop_rx(8'h80 + i[7:0]);
        chk("rts_n drained", rts_n, 1'h0);
        htu_host_model_i.ignore_rts = 1'b0;
        $display("test rx_fill done");
    endtask : t_rx_fill

    // Broken stop bit drops the byte; the next good one passes
    task automatic t_frame();
        htu_host_model_i.send_byte(8'h33, 1'h0, 1.0);
        repeat (60) @(negedge ref_clk);
        chk("frame error", ferr_cnt, 1);
        chk("no rx byte", user_rx_valid, 1'h0);
        htu_host_model_i.send_byte(8'h02, 1'h1, 1.0);
        pop_rx(8'h02);
        $display("test frame done");
    endtask : t_frame

    task automatic t_wake();
        @(negedge ref_clk);
        host_wake_req = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("host_wake off", host_wake, 1'h0);
        chk("sleep_ok off", device_sleep_ok, 1'h0);
        wake_enable = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("host_wake on", host_wake, 1'h1);
        chk("sleep_ok on", device_sleep_ok, 1'h1);
        device_wake_request = 1'b1;
        host_wake_req = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("host_wake idle", host_wake, 1'h0);
        chk("sleep_ok held", device_sleep_ok, 1'h0);
        $display("test wake done");
    endtask : t_wake

    // Hang guard, some margin above the expected 0.7 ms of traffic
    initial
    begin
        #(780_000);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        repeat (3) @(negedge ref_clk);
        chk("tx_out in reset", tx_out, 1'h1);
        chk("rts_n in reset", rts_n, 1'h1);
        chk("host_wake in reset", host_wake, 1'h0);
        chk("tx_ready in reset", user_tx_ready, 1'h1);
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("rts_n after reset", rts_n, 1'h0);
        t_link("default_rate");
        foreach (rates[i])
        begin
            set_rate(rates[i], 1'b1);
            t_link("rate");
        end
        set_rate(22'h2DC6C1, 1'b0);
        set_rate(22'h1C1FF, 1'b0);
        set_rate(22'h3FFFFF, 1'b0);
        t_link("refused_rate");
        t_frame();
        t_tx_fill();
        t_rx_fill();
        t_wake();
        chk("host stop bits", htu_host_model_i.bad_stop, 0);
        give_verdict();
    end
endmodule : testbench
